// ===== verilog/irq_unit_pkg.sv
// Package for the timer overflow interrupt unit
package irq_unit_pkg;
    localparam int PC_W = 11;
    localparam logic [PC_W-1:0] TIMER_VECTOR = 11'h008;
    localparam int CTRL_W = 8;
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_TIMER_EN = 2;
    localparam int BIT_TIMER_FLAG = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_USED_MASK = 8'h25;

    // Sequencer view of the unit
    typedef struct packed {
        logic instr_boundary;
        logic stack_full;
        logic [PC_W-1:0] next_pc;
        logic reti;
    } seq_in_s;

    typedef struct packed {
        logic push;
        logic [PC_W-1:0] push_pc;
        logic load_pc;
        logic [PC_W-1:0] load_addr;
    } seq_out_s;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_CALL = 2'b10
    } irq_state_e;
endpackage

// ===== verilog/timer_overflow_interrupt_unit.sv
// Timer overflow interrupt unit with control register and vectored call
// Notes on behaviour
// - One control register holds enables and flag
// - Timer overflow sets the request flag
// - Global enable cleared blocks every interrupt
// - Call 08H needs enables, flag, stack room
// - Push next PC, load vector, fetch
// - Service clears flag and global enable
// - Blocked requests stay latched for later
// - Full stack withholds acknowledge until pop
// - Flag holds until serviced or software clears
// - Return pops saved PC and resumes
// - Only PC is saved on entry
// - Writing 05h sets global and timer enables
// - Reset clears enables and request flag
`timescale 1ns/1ps
module timer_overflow_interrupt_unit
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic timer_overflow,
    input wire logic ctrl_wr,
    input wire logic [irq_unit_pkg::CTRL_W-1:0] ctrl_wdata,
    output logic [irq_unit_pkg::CTRL_W-1:0] ctrl_rdata,
    input wire irq_unit_pkg::seq_in_s seq_in,
    output irq_unit_pkg::seq_out_s seq_out,
    output logic irq_pending
);
    logic [irq_unit_pkg::CTRL_W-1:0] ctrl_r;
    logic [irq_unit_pkg::CTRL_W-1:0] ctrl_nxt;
    irq_unit_pkg::irq_state_e state_r;
    logic accept;
    logic [irq_unit_pkg::PC_W-1:0] saved_pc_r;

    function automatic logic ready_to_take(input logic [irq_unit_pkg::CTRL_W-1:0] c);
        return c[irq_unit_pkg::BIT_GLOBAL_EN] & c[irq_unit_pkg::BIT_TIMER_EN]
            & c[irq_unit_pkg::BIT_TIMER_FLAG];
    endfunction

    // Sequencer owns return-stack pop and PC restore; context save is software's job
    assign irq_pending = ready_to_take(ctrl_r);
    assign accept = irq_pending & ~seq_in.stack_full & seq_in.instr_boundary
        & (state_r == irq_unit_pkg::ST_RUN);

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr)
        begin
            ctrl_nxt = ctrl_wdata & irq_unit_pkg::CTRL_USED_MASK;
        end
        if (accept)
        begin
            ctrl_nxt[irq_unit_pkg::BIT_TIMER_FLAG] = 1'b0;
            ctrl_nxt[irq_unit_pkg::BIT_GLOBAL_EN] = 1'b0;
        end
        // Overflow wins over any clear in the same cycle
        if (timer_overflow)
        begin
            ctrl_nxt[irq_unit_pkg::BIT_TIMER_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_r <= irq_unit_pkg::CTRL_RESET;
        end
        else if (clk_en)
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_r <= irq_unit_pkg::ST_RUN;
        end
        else if (clk_en)
        begin
            case (state_r)
                irq_unit_pkg::ST_RUN:
                begin
                    if (accept)
                    begin
                        state_r <= irq_unit_pkg::ST_CALL;
                    end
                end
                irq_unit_pkg::ST_CALL:
                begin
                    // One call cycle also keeps accepts at least two cycles apart
                    state_r <= irq_unit_pkg::ST_RUN;
                end
                default:
                begin
                    state_r <= irq_unit_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            saved_pc_r <= '0;
        end
        else if (clk_en && accept)
        begin
            saved_pc_r <= seq_in.next_pc;
        end
    end

    // Push and load land together, one cycle after acceptance
    always_comb
    begin
        seq_out.push = (state_r == irq_unit_pkg::ST_CALL);
        seq_out.push_pc = saved_pc_r;
        seq_out.load_pc = (state_r == irq_unit_pkg::ST_CALL);
        seq_out.load_addr = irq_unit_pkg::TIMER_VECTOR;
    end

    assign ctrl_rdata = ctrl_r;

    chk_service_clears: assert property (@(posedge mclk) disable iff (srst)
        (accept && clk_en && !timer_overflow) |=>
        !ctrl_r[irq_unit_pkg::BIT_TIMER_FLAG] && !ctrl_r[irq_unit_pkg::BIT_GLOBAL_EN])
        else $error("service did not clear flag and global enable");
    chk_overflow_sets: assert property (@(posedge mclk) disable iff (srst)
        (timer_overflow && clk_en) |=> ctrl_r[irq_unit_pkg::BIT_TIMER_FLAG])
        else $error("overflow did not set flag");
    chk_global_blocks: assert property (@(posedge mclk) disable iff (srst)
        !ctrl_r[irq_unit_pkg::BIT_GLOBAL_EN] |-> !accept)
        else $error("accepted with global enable clear");
    chk_full_withholds: assert property (@(posedge mclk) disable iff (srst)
        seq_in.stack_full |-> !accept)
        else $error("accepted with full stack");
    chk_boundary_only: assert property (@(posedge mclk) disable iff (srst)
        !seq_in.instr_boundary |-> !accept)
        else $error("accepted mid instruction");
    sequence call_step;
        seq_out.push && seq_out.load_pc && seq_out.load_addr == irq_unit_pkg::TIMER_VECTOR;
    endsequence
    chk_vector_call: assert property (@(posedge mclk) disable iff (srst)
        (accept && clk_en) ##1 1'b1 |-> call_step)
        else $error("no vectored call after accept");
    chk_pc_saved: assert property (@(posedge mclk) disable iff (srst)
        (accept && clk_en) |=> seq_out.push_pc == $past(seq_in.next_pc))
        else $error("wrong PC pushed");
    chk_flag_holds: assert property (@(posedge mclk) disable iff (srst)
        (ctrl_r[irq_unit_pkg::BIT_TIMER_FLAG] && clk_en && !accept && !ctrl_wr)
        |=> ctrl_r[irq_unit_pkg::BIT_TIMER_FLAG])
        else $error("flag dropped without cause");
    chk_write_05: assert property (@(posedge mclk) disable iff (srst)
        (ctrl_wr && clk_en && ctrl_wdata == 8'h05 && !accept) |=>
        ctrl_r[irq_unit_pkg::BIT_GLOBAL_EN] && ctrl_r[irq_unit_pkg::BIT_TIMER_EN])
        else $error("write 05h did not enable");

    // Building blocks for the multi-step checks below
    sequence take_step;
        accept && clk_en;
    endsequence

    sequence frozen_step;
        !clk_en;
    endsequence

    chk_timer_gate: assert property (@(posedge mclk) disable iff (srst)
        !ctrl_r[irq_unit_pkg::BIT_TIMER_EN] |-> !accept)
        else $error("accepted with timer enable clear");

    chk_flag_gate: assert property (@(posedge mclk) disable iff (srst)
        !ctrl_r[irq_unit_pkg::BIT_TIMER_FLAG] |-> !accept)
        else $error("accepted with no request");

    chk_no_back_to_back: assert property (@(posedge mclk) disable iff (srst)
        take_step |=> !accept)
        else $error("second accept in call cycle");

    chk_push_one_cycle: assert property (@(posedge mclk) disable iff (srst)
        (seq_out.push && clk_en) |=> !seq_out.push)
        else $error("push stood longer than one cycle");

    // No disable here: this one watches reset itself
    chk_reset_clears: assert property (@(posedge mclk)
        srst |=> ctrl_r == irq_unit_pkg::CTRL_RESET && state_r == irq_unit_pkg::ST_RUN)
        else $error("reset left state behind");

    chk_freeze_holds: assert property (@(posedge mclk) disable iff (srst)
        frozen_step |=> $stable(ctrl_r) && $stable(state_r))
        else $error("state moved while clock enable low");

    chk_blocked_latched: assert property (@(posedge mclk) disable iff (srst)
        (timer_overflow && clk_en && !ctrl_r[irq_unit_pkg::BIT_GLOBAL_EN]) |=>
        ctrl_r[irq_unit_pkg::BIT_TIMER_FLAG])
        else $error("blocked request not latched");

    chk_unused_zero: assert property (@(posedge mclk) disable iff (srst)
        (ctrl_r & ~irq_unit_pkg::CTRL_USED_MASK) == 8'h00)
        else $error("unused control bit set");

    chk_write_replaces: assert property (@(posedge mclk) disable iff (srst)
        (ctrl_wr && clk_en && !accept && !timer_overflow) |=>
        ctrl_r == ($past(ctrl_wdata) & irq_unit_pkg::CTRL_USED_MASK))
        else $error("write did not replace register");

    chk_call_pair: assert property (@(posedge mclk) disable iff (srst)
        take_step |=> seq_out.push_pc == $past(seq_in.next_pc) && seq_out.load_pc)
        else $error("call did not pair push with load");
endmodule // timer_overflow_interrupt_unit

// ===== testbench/seq_model.sv
// Sequencer and return stack model facing the interrupt unit
`timescale 1ns/1ps
module seq_model #(parameter int DEPTH = 1)
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic boundary,
    input wire logic pop,
    input wire irq_unit_pkg::seq_out_s seq_out,
    output irq_unit_pkg::seq_in_s seq_in
);
    logic [10:0] pc_r;
    logic [10:0] saved_r;
    int depth_r;
    // Shallow stack so a single service fills it
    assign seq_in = {boundary, depth_r >= DEPTH, pc_r + 11'h001, pop};
    always_ff @(posedge mclk)
    begin
        if (srst)
            depth_r <= 0;
        else
            depth_r <= depth_r + int'(seq_out.push) - int'(pop);
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
            pc_r <= 11'h000;
        else if (seq_out.load_pc)
            pc_r <= seq_out.load_addr;
        else if (pop)
            pc_r <= saved_r;
    end
    // One saved entry only; no nested calls in these handlers
    always_ff @(posedge mclk)
    begin
        if (seq_out.push)
            saved_r <= seq_out.push_pc;
    end
endmodule // seq_model

// ===== testbench/timer_overflow_interrupt_unit_tb.sv
// Self-checking bench for the timer overflow interrupt unit
`timescale 1ns/1ps
module timer_overflow_interrupt_unit_tb;
    typedef struct packed {logic wr; logic [7:0] d; logic ovf; logic [7:0] r; logic p;} row_s;
    logic mclk = 0, srst = 1, ctrl_wr = 0, timer_overflow = 0, boundary = 0, pop = 0;
    logic clk_en = 1;
    logic [7:0] ctrl_wdata = 8'h00, ctrl_rdata;
    logic irq_pending;
    irq_unit_pkg::seq_in_s seq_in;
    irq_unit_pkg::seq_out_s seq_out;
    int err_total = 0, total_checks = 0;
    row_s rows [7] = '{'{1, 8'h05, 0, 8'h05, 0}, '{0, 8'h00, 1, 8'h25, 1},
        '{1, 8'h24, 0, 8'h24, 0}, '{1, 8'h21, 0, 8'h21, 0}, '{1, 8'h00, 0, 8'h00, 0},
        '{0, 8'h00, 1, 8'h20, 0}, '{1, 8'hFF, 0, 8'h25, 1}};
    always #12.5 mclk = ~mclk;
    timer_overflow_interrupt_unit dut_u (.mclk(mclk), .srst(srst), .clk_en(clk_en),
        .timer_overflow(timer_overflow), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .ctrl_rdata(ctrl_rdata), .seq_in(seq_in), .seq_out(seq_out), .irq_pending(irq_pending));
    seq_model #(.DEPTH(1)) model_u (.mclk(mclk), .srst(srst), .boundary(boundary), .pop(pop),
        .seq_out(seq_out), .seq_in(seq_in));
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task step(input logic wr, input logic [7:0] d, input logic ovf);
        @(posedge mclk);
        ctrl_wr <= wr;
        ctrl_wdata <= d;
        timer_overflow <= ovf;
        @(posedge mclk);
        ctrl_wr <= 0;
        timer_overflow <= 0;
        #1;
    endtask
    // Bounded wait for a call, then compare whether one came
    task wait_push(input int n, input logic exp);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            #1;
            if (seq_out.push === 1'b1)
                break;
        end
        chk(seq_out.push, exp);
    endtask
    task summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_total++;
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 0;
        #1;
        chk({ctrl_rdata, irq_pending, seq_out.push}, 16'h0000);
        foreach (rows[i])
        begin
            step(rows[i].wr, rows[i].d, rows[i].ovf);
            chk({ctrl_rdata, irq_pending}, {rows[i].r, rows[i].p});
        end
        chk(seq_out.push, 0);
        @(posedge mclk);
        boundary <= 1;
        wait_push(4, 1);
        chk({seq_out.push_pc, seq_out.load_pc}, {11'h001, 1'b1});
        chk(seq_out.load_addr, irq_unit_pkg::TIMER_VECTOR);
        chk(ctrl_rdata, 8'h04);
        step(1, 8'h25, 0);
        wait_push(6, 0);
        chk(irq_pending, 1);
        @(posedge mclk);
        pop <= 1;
        @(posedge mclk);
        pop <= 0;
        wait_push(4, 1);
        chk(seq_out.push_pc, 11'h002);
        // Frozen clock enable must swallow an overflow pulse
        @(posedge mclk);
        clk_en <= 0;
        timer_overflow <= 1;
        @(posedge mclk);
        clk_en <= 1;
        timer_overflow <= 0;
        #1;
        chk(ctrl_rdata, 8'h04);
        // Mid-run reset, then a write taken on the second edge after release
        @(posedge mclk);
        srst <= 1;
        repeat (2) @(posedge mclk);
        srst <= 0;
        #1;
        chk({ctrl_rdata, irq_pending, seq_out.push}, 16'h0000);
        step(1, 8'h05, 0);
        chk(ctrl_rdata, 8'h05);
        summarize();
    end
endmodule // timer_overflow_interrupt_unit_tb
